//--- src/cfg_field_decode.sv
`timescale 1ns/1ps
`include "meter_cfg_map.svh"
// decodes the upper configuration fields into their meaning
module cfg_field_decode (
  // configuration word
  input  wire logic [`CFG_WIDTH-1:0]    cfg,
  // decoded fields
  output meter_cfg_pkg::osc_trim_t      osc_trim,
  output meter_cfg_pkg::knom_t          rated_knom,
  output logic [3:0]                    extra_gain,
  output logic                          tamper_fine,
  output logic [31:0]                   step_cycles
);
  localparam int unsigned SHORT_CYC = `STEP_SHORT_US * `CLK_MHZ;
  localparam int unsigned LONG_CYC  = `STEP_LONG_US * `CLK_MHZ;
  logic [1:0] trim_raw;
  logic [1:0] mod_raw;
  // highest bit of each field is its msb
  assign trim_raw = cfg[`CFG_OSC_TRIM_MSB:`CFG_OSC_TRIM_LSB]; // RULE6
  assign mod_raw  = cfg[`CFG_RATED_MOD_MSB:`CFG_RATED_MOD_LSB]; // RULE6
  // values 0 and 3 both mean no trim
  always_comb begin
    case (trim_raw)
      `TRIM_PLUS10:  osc_trim = meter_cfg_pkg::trim_plus; // RULE1
      `TRIM_MINUS10: osc_trim = meter_cfg_pkg::trim_minus; // RULE1
      default:       osc_trim = meter_cfg_pkg::trim_none; // RULE1
    endcase
  end
  // rated voltage constants scaled by 10000
  always_comb begin
    case (mod_raw)
      2'h0:    rated_knom = 16'h0e0a; // RULE2
      2'h1:    rated_knom = 16'h0f42; // RULE2
      2'h2:    rated_knom = 16'h107b; // RULE2
      default: rated_knom = 16'h11b3; // RULE2
    endcase
  end
  assign extra_gain  = cfg[`CFG_EXTRA_GAIN_BIT] ? `EXTRA_GAIN_ON : `EXTRA_GAIN_OFF; // RULE3
  assign tamper_fine = cfg[`CFG_TAMPER_BIT]; // RULE4
  assign step_cycles = cfg[`CFG_STEPPER_BIT] ? LONG_CYC : SHORT_CYC; // RULE5
endmodule

//--- src/meter_cfg_map.svh
`ifndef METER_CFG_MAP_SVH
`define METER_CFG_MAP_SVH
// configuration word layout (bit positions in the 56-bit word)
`define CFG_WIDTH            56
`define CFG_OSC_TRIM_LSB     48
`define CFG_OSC_TRIM_MSB     49
`define CFG_RATED_MOD_LSB    50
`define CFG_RATED_MOD_MSB    51
`define CFG_EXTRA_GAIN_BIT   52
`define CFG_TAMPER_BIT       53
`define CFG_STEPPER_BIT      54
`define CFG_RESERVED_BIT     55
// mode bit indices
`define MODE_OSC_START       3'h0
`define MODE_PUMP_DRIVE      3'h1
`define MODE_CUR_CHOICE      3'h4
`define MODE_CFG_SOURCE      3'h5
`define MODE_OTP_WRITE       3'h6
// command byte fields
`define CMD_VALUE_BIT        7
`define CMD_MARK             3'h7
`define CMD_SWAP             8'hff
// reset values
`define MODE_RESET           8'h00
`define CFG_RESET            56'h0
// trim and gain encodings
`define TRIM_PLUS10          2'h1
`define TRIM_MINUS10         2'h2
`define EXTRA_GAIN_ON        4'h8
`define EXTRA_GAIN_OFF       4'h0
// stepper pulse widths in microseconds
`define STEP_SHORT_US        31250
`define STEP_LONG_US         156250
`define CLK_MHZ              25
`endif

//--- src/meter_cfg_pkg.sv
package meter_cfg_pkg;
  typedef enum logic [1:0] {
    trim_none  = 2'h0,
    trim_plus  = 2'h1,
    trim_minus = 2'h2
  } osc_trim_t;
  // rated voltage constant in units of 1/10000
  typedef logic [15:0] knom_t;
  typedef enum logic [2:0] {
    st_idle    = 3'h1,
    st_active  = 3'h2,
    st_clear   = 3'h4
  } link_state_t;
endpackage

//--- src/meter_config_and_mode_store.sv
`timescale 1ns/1ps
`include "meter_cfg_map.svh"
// Overview of operation
// (RULE1) two-bit oscillator trim at bits 48-49
// (RULE2) rated voltage modifier at bits 50-51
// (RULE3) bit 52 adds current gain of eight
// (RULE4) bit 53 picks tamper threshold
// (RULE5) bit 54 picks stepper pulse width
// (RULE6) 56 config bits, high bit is msb
// (RULE7) eight mode signals, three for test
// (RULE8) power-on clears modes, remote reset keeps
// (RULE9) command: value bit7, ones 6-4, index 3-1
// (RULE10) mode 0 starts the rc oscillator
// (RULE11) mode 1 turns motor pins into pump
// (RULE12) mode 4 chooses current channel two
// (RULE13) mode 5 sources config from shadow latches
// (RULE14) source select disconnects antifuse sense amps
// (RULE15) mode 6 also writes antifuse elements
// (RULE16) swap command reorders records, not retained
// (RULE17) signal clear acts at select idle, self-clears; code waits for all three link pins high
// (RULE18) while clear pending only swap accepted
// (RULE19) host writes modes by normal serial write
// (RULE20) link active only while select low
// (RULE21) strobe high reads, low writes
// (RULE22) reserved or unknown commands change nothing
// (RULE23) bit 55 stored, has no effect
module meter_config_and_mode_store #(
  parameter int CFG_BITS = `CFG_WIDTH
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 remote_reset,
  // serial link state
  input  wire logic                 serial_select_n,
  input  wire logic                 latch_dir_strobe,
  input  wire logic                 serial_clk,
  // received command byte
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_byte,
  // configuration write from the serial engine
  input  wire logic                 cfg_wr,
  input  wire logic [CFG_BITS-1:0]  cfg_wr_data,
  // antifuse contents
  input  wire logic [CFG_BITS-1:0]  antifuse_bits,
  // motor drive inputs from the stepper logic
  input  wire logic                 motor_pos_in,
  input  wire logic                 motor_neg_in,
  // mode outputs
  output logic [7:0]                mode_data_record,
  output logic                      osc_start,
  output logic                      current_input_choice,
  output logic                      cfg_from_shadow,
  output logic                      sense_amp_disconnect,
  output logic                      otp_write_enable,
  output logic                      antifuse_program,
  output logic                      record_swap,
  output logic                      system_signal_clear,
  // motor pins
  output logic                      motor_drive_pos,
  output logic                      motor_drive_neg,
  // configuration
  output logic [CFG_BITS-1:0]       cfg_active,
  output logic [CFG_BITS-1:0]       shadow_bits,
  // decoded fields
  output meter_cfg_pkg::osc_trim_t  osc_trim,
  output meter_cfg_pkg::knom_t      rated_knom,
  output logic [3:0]                extra_gain,
  output logic                      tamper_threshold_sel,
  output logic                      stepper_type_sel,
  output logic [31:0]               step_cycles
);
  logic [7:0]            mode;
  logic                  clear_pending;
  logic                  link_active;
  logic                  write_mode;
  logic                  cmd_ok;
  logic [2:0]            cmd_index;
  logic                  cmd_value;
  logic                  pump_phase;
  logic [7:0]            next_mode;
  logic                  cmd_marked;
  logic                  cmd_is_swap;
  logic                  cmd_reserved;
  logic                  swap_ok;
  logic                  cfg_wr_ok;
  logic                  select_n_q;
  logic                  frame_end;
  logic                  link_idle;
  meter_cfg_pkg::link_state_t state;
  meter_cfg_pkg::link_state_t next_state;

  // link is live only while select is low; write direction when strobe low
  assign link_active = !serial_select_n; // RULE20
  assign write_mode  = link_active && !latch_dir_strobe; // RULE21
  assign cmd_index   = cmd_byte[3:1]; // RULE9
  assign cmd_value   = cmd_byte[`CMD_VALUE_BIT]; // RULE9
  // all three link pins high marks the idle state of the link;
  // a pending clear waits for exactly this, not for select alone
  assign link_idle = serial_select_n && latch_dir_strobe && serial_clk; // RULE20

  // command classification, one flag per concern so each can be traced;
  // index 7 only carries the swap code, every other index 7 byte is dropped
  always_comb begin
    cmd_marked   = (cmd_byte[6:4] == `CMD_MARK); // RULE9
    cmd_is_swap  = (cmd_byte == `CMD_SWAP); // RULE16
    cmd_reserved = 1'b0;
    // bit 0 is a don't care; reserved indices 2 and 3 are dropped
    if (cmd_index == 3'h2) begin
      cmd_reserved = 1'b1; // RULE22
    end else if (cmd_index == 3'h3) begin
      cmd_reserved = 1'b1; // RULE22
    end else if (cmd_index == 3'h7) begin
      cmd_reserved = 1'b1; // RULE22
    end
    // a pending clear shuts out every mode command
    cmd_ok = cmd_valid && write_mode && cmd_marked && !cmd_is_swap &&
             !clear_pending && !cmd_reserved; // RULE18
    // the swap code alone still passes while a clear is pending
    swap_ok = cmd_valid && write_mode && cmd_is_swap; // RULE18
  end

  // configuration writes are frozen while a clear waits, so the
  // host cannot refill the shadow latches, which the clear leaves as they are
  assign cfg_wr_ok = cfg_wr && write_mode && !clear_pending;

  // next mode word: only the addressed bit may move, the
  // reserved test bits never change from here
  always_comb begin
    next_mode = mode;
    if (cmd_ok) begin
      case (cmd_index)
        `MODE_OSC_START: begin
          next_mode[0] = cmd_value; // RULE10
        end
        `MODE_PUMP_DRIVE: begin
          next_mode[1] = cmd_value; // RULE11
        end
        `MODE_CUR_CHOICE: begin
          next_mode[4] = cmd_value; // RULE12
        end
        `MODE_CFG_SOURCE: begin
          next_mode[5] = cmd_value; // RULE13
        end
        `MODE_OTP_WRITE: begin
          next_mode[6] = cmd_value; // RULE15
        end
        default: begin
          next_mode = mode; // RULE22
        end
      endcase
    end
  end

  // select as seen last cycle; resets to the idle level of the pin
  // so that no false frame end follows reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      select_n_q <= 1'b1;
    end else begin
      select_n_q <= serial_select_n;
    end
  end

  // a frame ends on the cycle select returns high
  assign frame_end = serial_select_n && !select_n_q; // RULE20

  // link state: idle, active, or clear, entered once the link is idle
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= meter_cfg_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      meter_cfg_pkg::st_idle: begin
        if (link_active) begin
          next_state = meter_cfg_pkg::st_active;
        end
      end
      meter_cfg_pkg::st_active: begin
        if (!link_active) begin
          next_state = meter_cfg_pkg::st_idle;
        end
      end
      meter_cfg_pkg::st_clear: begin
        next_state = meter_cfg_pkg::st_idle;
      end
      default: next_state = meter_cfg_pkg::st_idle;
    endcase
    // pending clear fires once all three link pins are idle high
    if (clear_pending && link_idle) begin
      next_state = meter_cfg_pkg::st_clear; // RULE17
    end
  end

  // mode bits; power-on reset and the clear state clear them, remote reset does not
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode <= `MODE_RESET; // RULE8
    end else if (state == meter_cfg_pkg::st_clear) begin
      mode <= `MODE_RESET; // RULE17
    end else begin
      mode <= next_mode; // RULE7
    end
  end

  // swap is a one-shot flag consumed by the next read; it is not
  // retained, so the host has to resend it before every swapped read
  // remote reset drops it too, since it is not one of the mode bits
  always_ff @(posedge mclk) begin
    if (reset || remote_reset) begin
      record_swap <= 1'b0;
    end else if (swap_ok) begin
      record_swap <= !record_swap; // RULE16
    end else if (frame_end && latch_dir_strobe) begin
      record_swap <= 1'b0; // RULE16
    end
  end

  // shadow latches; write to antifuse too when otp write enabled
  always_ff @(posedge mclk) begin
    if (reset) begin
      shadow_bits <= `CFG_RESET;
    end else if (state == meter_cfg_pkg::st_clear) begin
      shadow_bits[`CFG_RESERVED_BIT] <= shadow_bits[`CFG_RESERVED_BIT]; // RULE23
      shadow_bits[`CFG_STEPPER_BIT]  <= shadow_bits[`CFG_STEPPER_BIT];
    end else if (cfg_wr_ok) begin
      shadow_bits <= cfg_wr_data; // RULE23
    end
  end

  // system signal clear is a flag set by a host config write with command bit 0 high
  always_ff @(posedge mclk) begin
    if (reset) begin
      clear_pending <= 1'b0;
    end else if (state == meter_cfg_pkg::st_clear) begin
      clear_pending <= 1'b0; // RULE17
    end else if (cfg_wr_ok && cmd_byte[0]) begin
      clear_pending <= 1'b1; // RULE17
    end
  end

  // programming pulse to antifuse array
  always_ff @(posedge mclk) begin
    if (reset) begin
      antifuse_program <= 1'b0;
    end else begin
      antifuse_program <= cfg_wr_ok && mode[`MODE_OTP_WRITE]; // RULE15
    end
  end

  // pump phase toggles every clock in pump mode to drive a charge pump, else held low
  always_ff @(posedge mclk) begin
    if (reset) begin
      pump_phase <= 1'b0;
    end else begin
      pump_phase <= mode[`MODE_PUMP_DRIVE] ? !pump_phase : 1'b0;
    end
  end

  // motor pins registered; pump mode overrides stepper drive
  always_ff @(posedge mclk) begin
    if (reset) begin
      motor_drive_pos <= 1'b0;
      motor_drive_neg <= 1'b0;
    end else if (mode[`MODE_PUMP_DRIVE]) begin
      motor_drive_pos <= pump_phase; // RULE11
      motor_drive_neg <= !pump_phase; // RULE11
    end else begin
      motor_drive_pos <= motor_pos_in; // RULE11
      motor_drive_neg <= motor_neg_in;
    end
  end

  // configuration source mux
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_active <= `CFG_RESET;
    end else begin
      cfg_active <= mode[`MODE_CFG_SOURCE] ? shadow_bits : antifuse_bits; // RULE13
    end
  end

  // mode outputs; reserved bits 2,3 stay at zero
  always_comb begin
    mode_data_record     = mode; // RULE7
    osc_start            = mode[`MODE_OSC_START]; // RULE10
    current_input_choice = mode[`MODE_CUR_CHOICE]; // RULE12
    otp_write_enable     = mode[`MODE_OTP_WRITE]; // RULE15
  end

  // source select also isolates the sense amps, so the antifuse
  // gates never see the programming voltage while it is high
  always_comb begin
    cfg_from_shadow      = mode[`MODE_CFG_SOURCE]; // RULE13
    sense_amp_disconnect = mode[`MODE_CFG_SOURCE]; // RULE14
  end

  // status and single-bit fields of the live configuration
  always_comb begin
    system_signal_clear  = clear_pending; // RULE17
    tamper_threshold_sel = cfg_active[`CFG_TAMPER_BIT]; // RULE4
    stepper_type_sel     = cfg_active[`CFG_STEPPER_BIT]; // RULE5
  end

  // field decode of the live configuration
  cfg_field_decode u_decode (
    .cfg         (cfg_active),
    .osc_trim    (osc_trim),
    .rated_knom  (rated_knom),
    .extra_gain  (extra_gain),
    .tamper_fine (),
    .step_cycles (step_cycles)
  );
endmodule

//--- testbench/host_model.sv
`timescale 1ns/1ps
// host end of the command link; lines move just after mclk rises
module host_model (
  // clock
  input  wire logic   mclk,
  // link lines
  output logic        serial_select_n,
  output logic        latch_dir_strobe,
  output logic        serial_clk,
  // command and config write
  output logic        cmd_valid,
  output logic [7:0]  cmd_byte,
  output logic        cfg_wr,
  output logic [55:0] cfg_wr_data
);
  // lines start high, as the pull-ups leave them
  initial begin
    {serial_select_n, latch_dir_strobe, serial_clk} = 3'h7;
    {cmd_valid, cfg_wr, cmd_byte, cfg_wr_data} = '0;
  end
  // ordinary write frame: select low, strobe low
  task automatic cmd(input logic [7:0] b);
    @(posedge mclk);
    {serial_select_n, latch_dir_strobe, serial_clk} <= 3'h0;
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b; // stale byte must not look valid
  endtask
  task automatic cfg(input logic [55:0] d, input logic clr);
    @(posedge mclk);
    {serial_select_n, latch_dir_strobe, serial_clk} <= 3'h0;
    cfg_wr <= 1'b1;
    cfg_wr_data <= d;
    cmd_byte <= {7'h00, clr};
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_wr_data <= ~d;
  endtask
  // end of frame, all lines back high
  task automatic idle();
    @(posedge mclk);
    {serial_select_n, latch_dir_strobe, serial_clk} <= 3'h7;
  endtask
endmodule

//--- testbench/meter_config_and_mode_store_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (a), (e)); end end
module meter_config_and_mode_store_bench;
  logic mclk, reset, remote_reset, motor_pos_in, motor_neg_in;
  logic serial_select_n, latch_dir_strobe, serial_clk, cmd_valid, cfg_wr;
  logic [7:0] cmd_byte, mode_data_record;
  logic [55:0] cfg_wr_data, antifuse_bits, cfg_active, shadow_bits, d;
  logic osc_start, current_input_choice, cfg_from_shadow, sense_amp_disconnect;
  logic otp_write_enable, antifuse_program, record_swap, system_signal_clear;
  logic motor_drive_pos, motor_drive_neg, tamper_threshold_sel, stepper_type_sel;
  meter_cfg_pkg::osc_trim_t osc_trim;
  meter_cfg_pkg::knom_t rated_knom;
  logic [3:0] extra_gain;
  logic [31:0] step_cycles;
  logic [2:0] ix [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic [15:0] kv [4] = '{16'h0e0a, 16'h0f42, 16'h107b, 16'h11b3};
  logic [7:0] rsv [5] = '{8'hf4, 8'hf6, 8'hfe, 8'h74, 8'h77};
  logic [1:0] i;
  int error_cnt = 0, n_tests = 0, prog_cnt = 0;
  meter_config_and_mode_store i_dut (.*);
  host_model i_host (.*);
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  // counts write pulses into the antifuses
  always @(posedge mclk) prog_cnt <= prog_cnt + (antifuse_program === 1'b1);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse_reset(input logic por);
    @(posedge mclk);
    if (por) reset <= 1'b1; else remote_reset <= 1'b1;
    @(posedge mclk);
    {reset, remote_reset} <= 2'h0;
    tick(1);
  endtask
  task automatic t_modes();
    for (int j = 0; j < 5; j++) i_host.cmd({4'hf, ix[j], 1'b0});
    tick(1);
    `CHK(mode_data_record, 8'h73)
    `CHK({osc_start, current_input_choice, cfg_from_shadow, otp_write_enable}, 4'hf)
    `CHK(motor_drive_pos ^ motor_drive_neg, 1'b1)
    // reserved indices and index 7 other than the swap code
    foreach (rsv[j]) i_host.cmd(rsv[j]);
    tick(1);
    `CHK(mode_data_record, 8'h73)
    pulse_reset(1'b0);
    `CHK(mode_data_record, 8'h73)
    for (int j = 0; j < 5; j++) begin
      i_host.cmd({4'h7, ix[j], 1'b1});
      tick(1);
      `CHK(mode_data_record[ix[j]], 1'b0)
    end
    motor_pos_in <= 1'b1;
    motor_neg_in <= 1'b1;
    tick(2);
    `CHK({motor_drive_pos, motor_drive_neg}, 2'h3)
    i_host.cmd(8'hf0);
    pulse_reset(1'b1);
    `CHK(mode_data_record, 8'h00)
  endtask
  task automatic t_cfg();
    `CHK(cfg_active, antifuse_bits)
    antifuse_bits <= 56'h65_4321_0fed_cba9;
    tick(2);
    `CHK(cfg_active, 56'h65_4321_0fed_cba9)
    for (int j = 0; j < 4; j++) begin
      i = j[1:0];
      d = {1'b1, i[1], i[0], i[0], i, i, 48'h5a5a_c3c3_0ff0};
      i_host.cfg(d, 1'b0);
      i_host.cmd(8'hfa);
      tick(3);
      `CHK(cfg_active, d)
      `CHK(osc_trim, (i == 2'h3) ? 2'h0 : i)
      `CHK(rated_knom, kv[j])
      `CHK(extra_gain, i[0] ? 4'h8 : 4'h0)
      `CHK({tamper_threshold_sel, stepper_type_sel}, {i[0], i[1]})
      `CHK(step_cycles, i[1] ? 32'h003b_9aca : 32'h000b_ebc2)
    end
    `CHK(prog_cnt, 0)
    i_host.cmd(8'hfc);
    i_host.cfg(d, 1'b0);
    tick(3);
    `CHK(prog_cnt != 0, 1'b1)
    pulse_reset(1'b1);
  endtask
  task automatic t_clear();
    i_host.cmd(8'hf0);
    i_host.cfg(56'h0, 1'b1);
    tick(1);
    `CHK(system_signal_clear, 1'b1)
    i_host.cmd(8'hf2);
    tick(1);
    `CHK(mode_data_record, 8'h01)
    i_host.cmd(8'hff);
    tick(1);
    `CHK(record_swap, 1'b1)
    i_host.idle();
    tick(2);
    `CHK({mode_data_record, system_signal_clear, record_swap}, 10'h000)
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog sized well beyond the roughly 115 cycles of the run
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {reset, remote_reset, motor_pos_in, motor_neg_in} = 4'h8;
    antifuse_bits = 56'h12_3456_789a_bcde;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    tick(1);
    `CHK(mode_data_record, 8'h00)
    t_modes();
    t_cfg();
    t_clear();
    end_of_test();
  end
endmodule

//--- testbench/meter_store_chk.sv
`timescale 1ns/1ps
// watches mode handling at the block's ports
module meter_store_chk (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // link and commands
  input wire logic       serial_select_n,
  input wire logic       latch_dir_strobe,
  input wire logic       serial_clk,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  // mode state and motor
  input wire logic [7:0] mode_data_record,
  input wire logic       osc_start,
  input wire logic       cfg_from_shadow,
  input wire logic       sense_amp_disconnect,
  input wire logic       record_swap,
  input wire logic       system_signal_clear,
  input wire logic       motor_pos_in,
  input wire logic       motor_drive_pos
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // a command that the block must take
  logic tk;
  assign tk = cmd_valid && !serial_select_n && !latch_dir_strobe && !system_signal_clear;
  osc_set_a: assert property (tk && cmd_byte[7:1] == 7'h78 |=> osc_start) else $error("osc set");
  osc_clr_a: assert property (tk && cmd_byte[7:1] == 7'h38 |=> !osc_start) else $error("osc clr");
  rsvd_hold_a: assert property (tk && cmd_byte[3:1] inside {3'h2, 3'h3} |=> $stable(mode_data_record)) else $error("rsvd");
  // no command and no clear: nothing else, remote reset included, may move the modes
  quiet_hold_a: assert property (!cmd_valid && !system_signal_clear |=> $stable(mode_data_record)) else $error("hold");
  por_clear_a: assert property (disable iff (1'b0) reset |=> mode_data_record == 8'h00) else $error("por");
  src_sense_a: assert property (cfg_from_shadow == mode_data_record[5] && sense_amp_disconnect == mode_data_record[5]) else $error("src");
  clr_block_a: assert property (system_signal_clear && cmd_valid && !serial_select_n && cmd_byte != 8'hff |=> $stable(mode_data_record)) else $error("block");
  // the clear state takes one edge to enter and a second to wipe the modes
  clr_idle_a: assert property (system_signal_clear && serial_select_n && latch_dir_strobe && serial_clk |-> ##2 mode_data_record == 8'h00 && !system_signal_clear) else $error("clear");
  swap_flip_a: assert property (tk && cmd_byte == 8'hff |=> record_swap != $past(record_swap)) else $error("swap");
  motor_norm_a: assert property (!mode_data_record[1] ##1 !mode_data_record[1] |-> motor_drive_pos == $past(motor_pos_in)) else $error("motor");
endmodule
bind meter_config_and_mode_store meter_store_chk i_chk (.*);
